//--- src/pdrc_cfg.svh
// Contract
// - post-divider writes apply at once; dropped while that pll is panel-protected
// - divisor sets ignore writes while panel-protected
// - bit 27 gates doubler clock on/off
// - cpu output 00 disables, 01 reserved
// - cpu output 10 drives downspread clock
// - cpu output 11 drives non-spread clock
// - spread source field enables spread clock
// - centre bit selects superspread centre spread
// - bit 1 enables downspread modulator
// - bit 0 clear disables superspread modulator
`ifndef PDRC_CFG_SVH
`define PDRC_CFG_SVH
// register byte addresses
`define PDRC_PLL_A_CTL 20'hc6014
`define PDRC_PLL_B_CTL 20'hc6018
`define PDRC_PLL_A_SET0 20'hc6040
`define PDRC_PLL_A_SET1 20'hc6044
`define PDRC_PLL_B_SET0 20'hc6048
`define PDRC_PLL_B_SET1 20'hc604c
`define PDRC_REF_CTL 20'hc6200
// reset values
`define PDRC_SET_RST 32'h00000000
`define PDRC_REF_RST 32'h00000000
`define PDRC_POSTDIV_RST 8'h80
// writable bit masks
`define PDRC_SET_MASK 32'h09ff3f3f
`define PDRC_REF_MASK 32'h00007fc3
// field positions
`define PDRC_SET_DBL_BIT 27
`define PDRC_REF_SUPER_MOD_BIT 0
`define PDRC_REF_DOWN_MOD_BIT 1
`define PDRC_REF_CENTRE_BIT 6
`define PDRC_REF_SUPER_LSB 7
`define PDRC_REF_NONSP_LSB 9
`define PDRC_REF_SSC_LSB 11
`define PDRC_REF_CPU_LSB 13
// two-bit source field codes
`define PDRC_SRC_ENABLED 2'h2
`define PDRC_NONSP_EXT 2'h1
`define PDRC_NONSP_INT 2'h2
`endif

//--- src/pdrc_pkg.sv
package pdrc_pkg;
   // cpu clock output selection
   typedef enum logic [1:0] {
      PDRC_CPU_OFF = 2'h0,
      PDRC_CPU_RSVD = 2'h1,
      PDRC_CPU_DOWN = 2'h2,
      PDRC_CPU_NONSP = 2'h3
   } pdrc_cpu_sel_t;
   // one register word
   typedef logic [31:0] pdrc_word_t;
endpackage

//--- src/pdrc_divset.sv
`timescale 1ns/100ps
`default_nettype none
`include "pdrc_cfg.svh"
module pdrc_divset import pdrc_pkg::*; (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // accepted write and its data
   input wire logic i_wr_en,
   input wire pdrc_word_t i_wdata,
   // transcoder vertical blank pulse
   input wire logic i_vblank,
   // armed and applied values
   output pdrc_word_t o_shadow,
   output pdrc_word_t o_active,
   output logic o_doubler_en
);
   pdrc_word_t shadow_q, shadow_d; // armed value
   pdrc_word_t active_q, active_d; // value the pll uses

   ////////////////////////////////////////////////////////////
   // next values: masked write, copy on vblank
   always_comb begin
      shadow_d = shadow_q;
      active_d = active_q;
      if (i_wr_en) begin
         shadow_d = i_wdata & `PDRC_SET_MASK;
      end
      if (i_vblank) begin
         active_d = shadow_q;
      end
   end

   // registers
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         shadow_q <= `PDRC_SET_RST;
         active_q <= `PDRC_SET_RST;
      end else begin
         shadow_q <= shadow_d;
         active_q <= active_d;
      end
   end

   assign o_shadow = shadow_q;
   assign o_active = active_q;
   assign o_doubler_en = active_q[`PDRC_SET_DBL_BIT];

   ////////////////////////////////////////////////////////////
   // checks
   property p_vblank_apply;
      @(posedge i_clk) disable iff (i_srst)
      i_vblank |=> (active_q == $past(shadow_q));
   endproperty
   a_vblank_apply: assert property (p_vblank_apply)
      else $error("active set not loaded at vblank");

   property p_hold_no_vblank;
      @(posedge i_clk) disable iff (i_srst)
      !i_vblank && !i_srst |=> $stable(active_q);
   endproperty
   a_hold_no_vblank: assert property (p_hold_no_vblank)
      else $error("active set changed outside vblank");

   property p_rsvd_zero;
      @(posedge i_clk) disable iff (i_srst)
      i_wr_en |=> ((shadow_q & ~`PDRC_SET_MASK) == 32'h00000000);
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero)
      else $error("reserved divisor bits not zero");

   property p_doubler;
      @(posedge i_clk) disable iff (i_srst)
      i_vblank ##1 1'b1 |-> o_doubler_en == $past(shadow_q[27]);
   endproperty
   a_doubler: assert property (p_doubler)
      else $error("doubler gate does not follow bit 27");
endmodule
`default_nettype wire

//--- src/pdrc_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "pdrc_cfg.svh"
module pdrc_top import pdrc_pkg::*; (
   // clock and reset
   input wire logic i_clk,
   input wire logic i_srst,
   // mmio register port
   input wire logic i_wr_en,
   input wire logic i_rd_en,
   input wire logic [19:0] i_addr,
   input wire pdrc_word_t i_wdata,
   output logic o_rd_valid,
   output pdrc_word_t o_rd_data,
   // panel power sequencer protect, per pll
   input wire logic i_protect_a,
   input wire logic i_protect_b,
   // transcoder vertical blank pulse, per pll
   input wire logic i_vblank_a,
   input wire logic i_vblank_b,
   // applied divisor sets
   output pdrc_word_t o_pll_a_set0,
   output pdrc_word_t o_pll_a_set1,
   output pdrc_word_t o_pll_b_set0,
   output pdrc_word_t o_pll_b_set1,
   output logic [3:0] o_doubler_en,
   // one-hot post dividers
   output logic [7:0] o_post_div_a,
   output logic [7:0] o_post_div_b,
   // reference clock sources and modulators
   output logic o_ssc_src_en,
   output logic o_nonsp_ext_en,
   output logic o_nonsp_int_en,
   output logic o_super_src_en,
   output logic o_super_centre,
   output logic o_super_mod_en,
   output logic o_down_mod_en,
   // clock output toward the cpu
   output logic o_cpu_down_en,
   output logic o_cpu_nonsp_en
);
   ////////////////////////////////////////////////////////////
   // address decode
   logic [3:0] set_hit; // divisor set selected
   logic [3:0] set_wr; // divisor write accepted
   logic [3:0] set_vb; // vblank per set
   logic [1:0] prot; // protect per set pair
   logic hit_ca, hit_cb, hit_ref; // other registers
   logic ctl_wr_a, ctl_wr_b, ref_wr; // accepted writes

   assign prot = {i_protect_b, i_protect_a};
   assign set_vb = {i_vblank_b, i_vblank_b, i_vblank_a, i_vblank_a};

   // decode and protect gating
   always_comb begin
      set_hit = 4'h0;
      hit_ca = 1'b0;
      hit_cb = 1'b0;
      hit_ref = 1'b0;
      case (i_addr)
         `PDRC_PLL_A_SET0: set_hit = 4'h1;
         `PDRC_PLL_A_SET1: set_hit = 4'h2;
         `PDRC_PLL_B_SET0: set_hit = 4'h4;
         `PDRC_PLL_B_SET1: set_hit = 4'h8;
         `PDRC_PLL_A_CTL: hit_ca = 1'b1;
         `PDRC_PLL_B_CTL: hit_cb = 1'b1;
         `PDRC_REF_CTL: hit_ref = 1'b1;
         default: set_hit = 4'h0; // unmapped
      endcase
      // protected sets drop the write
      set_wr[0] = i_wr_en && set_hit[0] && !prot[0];
      set_wr[1] = i_wr_en && set_hit[1] && !prot[0];
      set_wr[2] = i_wr_en && set_hit[2] && !prot[1];
      set_wr[3] = i_wr_en && set_hit[3] && !prot[1];
      ctl_wr_a = i_wr_en && hit_ca && !i_protect_a;
      ctl_wr_b = i_wr_en && hit_cb && !i_protect_b;
      ref_wr = i_wr_en && hit_ref;
   end

   ////////////////////////////////////////////////////////////
   // divisor sets, double buffered
   pdrc_word_t set_shadow [4]; // readable armed values
   pdrc_word_t set_active [4]; // applied values
   logic [3:0] dbl_en; // doubler gates

   for (genvar g = 0; g < 4; g++) begin : g_set
      pdrc_divset u_set (
         .i_clk(i_clk),
         .i_srst(i_srst),
         .i_wr_en(set_wr[g]),
         .i_wdata(i_wdata),
         .i_vblank(set_vb[g]),
         .o_shadow(set_shadow[g]),
         .o_active(set_active[g]),
         .o_doubler_en(dbl_en[g])
      );
   end

   assign o_pll_a_set0 = set_active[0];
   assign o_pll_a_set1 = set_active[1];
   assign o_pll_b_set0 = set_active[2];
   assign o_pll_b_set1 = set_active[3];
   assign o_doubler_en = dbl_en;

   ////////////////////////////////////////////////////////////
   // post dividers, not double buffered
   logic [7:0] pdiv_a_q, pdiv_a_d; // pll a post divider
   logic [7:0] pdiv_b_q, pdiv_b_d; // pll b post divider

   // next values: write lands on the next edge
   always_comb begin
      pdiv_a_d = pdiv_a_q;
      pdiv_b_d = pdiv_b_q;
      if (ctl_wr_a) begin
         pdiv_a_d = i_wdata[7:0];
      end
      if (ctl_wr_b) begin
         pdiv_b_d = i_wdata[7:0];
      end
   end

   // registers
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         pdiv_a_q <= `PDRC_POSTDIV_RST;
         pdiv_b_q <= `PDRC_POSTDIV_RST;
      end else begin
         pdiv_a_q <= pdiv_a_d;
         pdiv_b_q <= pdiv_b_d;
      end
   end

   assign o_post_div_a = pdiv_a_q;
   assign o_post_div_b = pdiv_b_q;

   ////////////////////////////////////////////////////////////
   // reference clock control
   pdrc_word_t ref_q, ref_d; // stored control word
   pdrc_cpu_sel_t cpu_sel; // cpu output field
   logic ssc_on, down_on, nonsp_on; // decoded sources

   // next value: reserved bits never stored
   always_comb begin
      ref_d = ref_q;
      if (ref_wr) begin
         ref_d = i_wdata & `PDRC_REF_MASK;
      end
   end

   // register
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         ref_q <= `PDRC_REF_RST;
      end else begin
         ref_q <= ref_d;
      end
   end

   // field decode of the stored word
   always_comb begin
      cpu_sel = pdrc_cpu_sel_t'(ref_q[`PDRC_REF_CPU_LSB +: 2]);
      ssc_on = ref_q[`PDRC_REF_SSC_LSB +: 2] == `PDRC_SRC_ENABLED;
      down_on = ref_q[`PDRC_REF_DOWN_MOD_BIT];
      nonsp_on = ref_q[`PDRC_REF_NONSP_LSB +: 2] != 2'h0;
   end

   logic src_q [9]; // registered source controls

   // source controls, registered on every edge
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         for (int k = 0; k < 9; k++) begin
            src_q[k] <= 1'b0;
         end
      end else begin
         src_q[0] <= ssc_on;
         // all fields from the stored word, so every output moves together
         src_q[1] <= ref_q[`PDRC_REF_NONSP_LSB +: 2] == `PDRC_NONSP_EXT;
         src_q[2] <= ref_q[`PDRC_REF_NONSP_LSB +: 2] == `PDRC_NONSP_INT;
         src_q[3] <= ref_q[`PDRC_REF_SUPER_LSB +: 2] == `PDRC_SRC_ENABLED;
         src_q[4] <= ref_q[`PDRC_REF_CENTRE_BIT];
         src_q[5] <= ref_q[`PDRC_REF_SUPER_MOD_BIT];
         src_q[6] <= down_on;
         // downspread only with its source and modulator up
         src_q[7] <= cpu_sel == PDRC_CPU_DOWN && ssc_on && down_on;
         // non-spread only with its source up; 00 and 01 keep off
         src_q[8] <= cpu_sel == PDRC_CPU_NONSP && nonsp_on;
      end
   end

   assign o_ssc_src_en = src_q[0];
   assign o_nonsp_ext_en = src_q[1];
   assign o_nonsp_int_en = src_q[2];
   assign o_super_src_en = src_q[3];
   assign o_super_centre = src_q[4];
   assign o_super_mod_en = src_q[5];
   assign o_down_mod_en = src_q[6];
   assign o_cpu_down_en = src_q[7];
   assign o_cpu_nonsp_en = src_q[8];

   ////////////////////////////////////////////////////////////
   // read path, one cycle after the request
   logic rd_valid_q, rd_valid_d; // read answer strobe
   pdrc_word_t rd_data_q, rd_data_d; // read answer data

   // read mux; unmapped reads zero
   always_comb begin
      rd_valid_d = i_rd_en;
      rd_data_d = 32'h00000000;
      if (i_rd_en) begin
         case (i_addr)
            `PDRC_PLL_A_SET0: rd_data_d = set_shadow[0];
            `PDRC_PLL_A_SET1: rd_data_d = set_shadow[1];
            `PDRC_PLL_B_SET0: rd_data_d = set_shadow[2];
            `PDRC_PLL_B_SET1: rd_data_d = set_shadow[3];
            `PDRC_PLL_A_CTL: rd_data_d = {24'h000000, pdiv_a_q};
            `PDRC_PLL_B_CTL: rd_data_d = {24'h000000, pdiv_b_q};
            `PDRC_REF_CTL: rd_data_d = ref_q;
            default: rd_data_d = 32'h00000000;
         endcase
      end
   end

   // registers
   always_ff @(posedge i_clk) begin
      if (i_srst) begin
         rd_valid_q <= 1'b0;
         rd_data_q <= 32'h00000000;
      end else begin
         rd_valid_q <= rd_valid_d;
         rd_data_q <= rd_data_d;
      end
   end

   assign o_rd_valid = rd_valid_q;
   assign o_rd_data = rd_data_q;

   ////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_srst);

   property p_postdiv_now;
      ctl_wr_a |=> o_post_div_a == $past(i_wdata[7:0]);
   endproperty
   a_postdiv_now: assert property (p_postdiv_now)
      else $error("post divider write not immediate");

   property p_protect;
      i_wr_en && set_hit[0] && i_protect_a |=> $stable(set_shadow[0]);
   endproperty
   a_protect: assert property (p_protect)
      else $error("protected divisor set was written");

   property p_cpu_off;
      !i_srst && (cpu_sel == PDRC_CPU_OFF || cpu_sel == PDRC_CPU_RSVD)
         |=> !o_cpu_down_en && !o_cpu_nonsp_en;
   endproperty
   a_cpu_off: assert property (p_cpu_off)
      else $error("cpu output on while disabled");

   property p_cpu_down;
      !i_srst && cpu_sel == PDRC_CPU_DOWN && ssc_on && down_on |=> o_cpu_down_en;
   endproperty
   a_cpu_down: assert property (p_cpu_down)
      else $error("downspread cpu output missing");

   property p_cpu_nonsp;
      !i_srst && cpu_sel == PDRC_CPU_NONSP && nonsp_on |=> o_cpu_nonsp_en;
   endproperty
   a_cpu_nonsp: assert property (p_cpu_nonsp)
      else $error("non-spread cpu output missing");

   property p_ssc_src;
      ref_wr ##1 1'b1 |=> o_ssc_src_en == ($past(i_wdata[12:11], 2) == 2'h2);
   endproperty
   a_ssc_src: assert property (p_ssc_src)
      else $error("spread source enable wrong");

   property p_centre;
      ref_wr ##2 1'b1 |-> o_super_centre == $past(i_wdata[6], 2);
   endproperty
   a_centre: assert property (p_centre)
      else $error("centre spread select wrong");

   property p_mods;
      ref_wr ##2 1'b1 |-> o_down_mod_en == $past(i_wdata[1], 2)
         && o_super_mod_en == $past(i_wdata[0], 2);
   endproperty
   a_mods: assert property (p_mods)
      else $error("modulator enables wrong");

   property p_ref_rsvd;
      i_rd_en && hit_ref |=> (o_rd_data & ~`PDRC_REF_MASK) == 32'h00000000;
   endproperty
   a_ref_rsvd: assert property (p_ref_rsvd)
      else $error("reserved reference bits read nonzero");

   c_protect_drop: cover property (i_wr_en && set_hit[2] && i_protect_b);
   c_vblank_apply: cover property (set_wr[0] ##[1:20] i_vblank_a);
   c_cpu_down: cover property (o_cpu_down_en);
   c_cpu_nonsp: cover property (o_cpu_nonsp_en);
endmodule
`default_nettype wire

//--- dv/pdrc_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`include "pdrc_cfg.svh"
module pdrc_tb_top import pdrc_pkg::*;;
   ////////////////////////////////////////////////////////////////////////
   // one table row: ref ctl write beside expected source flags
   typedef struct packed {
      pdrc_word_t data;
      logic [8:0] flags;
   } pdrc_row_t;
   logic clk, srst, wr_en, rd_en, rd_valid; // port stimulus and strobe
   logic [19:0] addr; // byte address
   pdrc_word_t wdata, rd_data, a0, a1, b0, b1; // data and applied sets
   logic protect_a, protect_b, vblank_a, vblank_b; // sequencer inputs
   logic [3:0] doubler_en; // doubler gates
   logic [7:0] post_div_a, post_div_b; // post dividers
   logic ssc, n_ext, n_int, s_src, s_ctr, s_mod, d_mod, cpu_d, cpu_n;
   logic [8:0] flags; // source flags, msb first
   int err_total = 0; // mismatch count
   int n_checks = 0; // comparison count
   // flags: ssc ext int super centre supermod downmod cpudown cpunonsp
   pdrc_row_t rows [10] = '{
      '{32'h00001000, 9'h100}, '{32'h00005002, 9'h106},
      '{32'h00005000, 9'h100}, '{32'h00004000, 9'h000},
      '{32'h00006200, 9'h081}, '{32'h00006400, 9'h041},
      '{32'h00003002, 9'h104}, '{32'h00000141, 9'h038},
      '{32'h00000100, 9'h020}, '{32'hffffffff, 9'h01d}};
   logic [19:0] set_addr [4] = '{`PDRC_PLL_A_SET0, `PDRC_PLL_A_SET1,
      `PDRC_PLL_B_SET0, `PDRC_PLL_B_SET1};
   // divisor words, first one with reserved bits set
   pdrc_word_t set_data [4] = '{32'hfe02d2c5, 32'h00001007, 32'h08c30e03,
      32'h00c61406};
   assign flags = {ssc, n_ext, n_int, s_src, s_ctr, s_mod, d_mod, cpu_d, cpu_n};
   ////////////////////////////////////////////////////////////////////////
   // design under test
   pdrc_top dut (.i_clk(clk), .i_srst(srst), .i_wr_en(wr_en), .i_rd_en(rd_en),
      .i_addr(addr), .i_wdata(wdata), .o_rd_valid(rd_valid), .o_rd_data(rd_data),
      .i_protect_a(protect_a), .i_protect_b(protect_b), .i_vblank_a(vblank_a),
      .i_vblank_b(vblank_b), .o_pll_a_set0(a0), .o_pll_a_set1(a1),
      .o_pll_b_set0(b0), .o_pll_b_set1(b1), .o_doubler_en(doubler_en),
      .o_post_div_a(post_div_a), .o_post_div_b(post_div_b), .o_ssc_src_en(ssc),
      .o_nonsp_ext_en(n_ext), .o_nonsp_int_en(n_int), .o_super_src_en(s_src),
      .o_super_centre(s_ctr), .o_super_mod_en(s_mod), .o_down_mod_en(d_mod),
      .o_cpu_down_en(cpu_d), .o_cpu_nonsp_en(cpu_n));
   ////////////////////////////////////////////////////////////////////////
   // free running clock, 8 ns
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // word compare
   task automatic chk_word(input pdrc_word_t got, input pdrc_word_t exp, input string what);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // flag group compare
   task automatic chk_bits(input logic [8:0] got, input logic [8:0] exp, input string what);
      n_checks++;
      if (got !== exp) begin
         err_total++;
         $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask
   // one write, ends on the taking edge
   task automatic wr(input logic [19:0] a, input pdrc_word_t d);
      @(posedge clk);
      wr_en <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   // one read, answer checked just after the taking edge
   task automatic rd(input logic [19:0] a, input pdrc_word_t exp);
      @(posedge clk);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      chk_bits({8'h00, rd_valid}, 9'h001, "read strobe");
      chk_word(rd_data, exp, "read data");
   endtask
   // one vblank pulse, returns after the apply edge
   task automatic vb(input logic sel_b);
      @(posedge clk);
      vblank_a <= !sel_b;
      vblank_b <= sel_b;
      @(posedge clk);
      vblank_a <= 1'b0;
      vblank_b <= 1'b0;
      @(posedge clk);
      #1;
   endtask
   // verdict and end of run
   task automatic summarize();
      if (err_total == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // watchdog, run needs well under 1000 cycles
   initial begin
      repeat (5000) @(posedge clk);
      err_total++;
      summarize();
   end
   // main sequence
   initial begin
      {wr_en, rd_en, protect_a, protect_b, vblank_a, vblank_b} = 6'h00;
      addr = 20'h00000;
      wdata = 32'h00000000;
      srst = 1'b1;
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      #1;
      // reset values
      chk_word({24'h000000, post_div_a}, 32'h00000080, "post div a reset");
      chk_word(a0, 32'h00000000, "set reset");
      chk_bits(flags, 9'h000, "ref outputs reset");
      rd(`PDRC_REF_CTL, 32'h00000000);
      // table of reference control settings
      foreach (rows[i]) begin
         wr(`PDRC_REF_CTL, rows[i].data);
         repeat (2) @(posedge clk);
         #1;
         chk_bits(flags, rows[i].flags, "ref outputs");
         rd(`PDRC_REF_CTL, rows[i].data & `PDRC_REF_MASK);
      end
      // divisor sets armed, applied only at vblank
      foreach (set_addr[i]) begin
         wr(set_addr[i], set_data[i]);
         rd(set_addr[i], set_data[i] & `PDRC_SET_MASK);
      end
      chk_word(a0, 32'h00000000, "set applied early");
      vb(1'b0);
      chk_word(a0, set_data[0] & `PDRC_SET_MASK, "a0 applied");
      chk_word(a1, set_data[1], "a1 applied");
      chk_word(b0, 32'h00000000, "b0 applied by a");
      vb(1'b1);
      chk_word(b0, set_data[2], "b0 applied");
      chk_word(b1, set_data[3], "b1 applied");
      chk_bits({5'h00, doubler_en}, 9'h005, "doubler gates");
      // pll a protected, pll b stays writable
      @(posedge clk);
      protect_a <= 1'b1;
      wr(`PDRC_PLL_A_SET0, 32'h00000000);
      rd(`PDRC_PLL_A_SET0, set_data[0] & `PDRC_SET_MASK);
      wr(`PDRC_PLL_B_SET0, 32'h00000000);
      rd(`PDRC_PLL_B_SET0, 32'h00000000);
      vb(1'b0);
      chk_word(a0, set_data[0] & `PDRC_SET_MASK, "protected set");
      // now pll b protected, pll a free again
      @(posedge clk);
      protect_a <= 1'b0;
      protect_b <= 1'b1;
      wr(`PDRC_PLL_B_SET0, 32'h00000101);
      rd(`PDRC_PLL_B_SET0, 32'h00000000);
      @(posedge clk);
      protect_b <= 1'b0;
      // post divider takes effect with no vblank
      wr(`PDRC_PLL_A_CTL, 32'h00000004);
      @(posedge clk);
      #1;
      chk_word({24'h000000, post_div_a}, 32'h00000004, "post div a");
      wr(`PDRC_PLL_B_CTL, 32'hffffff01);
      @(posedge clk);
      #1;
      chk_word({24'h000000, post_div_b}, 32'h00000001, "post div b");
      // unmapped address
      wr(20'hc6100, 32'hffffffff);
      rd(20'hc6100, 32'h00000000);
      // second reset in mid run
      @(posedge clk);
      srst <= 1'b1;
      @(posedge clk);
      srst <= 1'b0;
      #1;
      chk_word(a0, 32'h00000000, "set after reset");
      chk_word({24'h000000, post_div_a}, 32'h00000080, "post div after reset");
      summarize();
   end
endmodule
`default_nettype wire
